/* File: asra_regs.svh */
// register map, field positions, reset values and frame constants
`ifndef ASRA_REGS_SVH
`define ASRA_REGS_SVH
`define ASRA_FRAME_BITS      5'd16
`define ASRA_CRC_FRAME_BITS  5'd24
`define ASRA_BIT_CNT_MAX     5'h1F
`define ASRA_DIR_BIT         15
`define ASRA_IDX_HI          14
`define ASRA_IDX_LO          12
`define ASRA_IDX_CFG1        3'h1
`define ASRA_IDX_CFG2        3'h2
`define ASRA_IDX_ALARM       3'h3
`define ASRA_IDX_LOW_LIM     3'h4
`define ASRA_IDX_HIGH_LIM    3'h5
`define ASRA_CFG1_RESET      12'h000
`define ASRA_CFG2_RESET      12'h000
`define ASRA_LOW_LIM_RESET   12'h800
`define ASRA_HIGH_LIM_RESET  12'h7FF
`define ASRA_CFG1_WMASK      12'h3FF
`define ASRA_CFG2_WMASK      12'h1FF
`define ASRA_CFG1_CRC_W_BIT  5
`define ASRA_CRC_POLY        8'h07
`define ASRA_CRC_INIT        8'hFF
`endif

/* File: asra_pkg.sv */
// types for the serial register access block
`default_nettype none
package asra_pkg;
  typedef enum logic {ASRA_IDLE, ASRA_ACTIVE} asra_frame_t;
  typedef logic [11:0] asra_data_t;
endpackage
`default_nettype wire

/* File: asra_serial_regs.sv */
// serial register access: frame decode, register bank, read-back shifter
`include "asra_regs.svh"
`default_nettype none
// Function
// - frames are 16 clocks, or 24 with checksum, MSB first
// - top bit one writes, zero reads
// - next three bits select target register
// - write loads low twelve bits into register, config reserved bits masked to zero
// - read data returns during following frame
// - index 0, 6, 7 reads return conversions
// - writes to read-only register change nothing
// - writes to undefined indexes are no-ops
// - primary config at 1, reset zero
// - alarm register at 3 reports flags
// - lower limit at 4 resets 0x800
// - upper limit at 5 resets 0x7FF
// - checksummed writes need valid checksum else dropped
// - read-back top nibble carries addressing field
module asra_serial_regs
  import asra_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        serial_clk,
  input  wire logic        frame_sel_n,
  input  wire logic        serial_command_in,
  input  wire logic [15:0] conv_result_a,
  input  wire logic        setup_event,
  input  wire logic        chan_a_over_event,
  input  wire logic        chan_a_under_event,
  input  wire logic        chan_b_over_event,
  input  wire logic        chan_b_under_event,
  output logic             serial_out_a,
  output asra_data_t       config_primary,
  output asra_data_t       config_secondary,
  output asra_data_t       lower_alarm_limit,
  output asra_data_t       upper_alarm_limit,
  output logic [5:0]       alarm_flags
);

  // checksum over a 16-bit command, top byte inverted via all-ones start
  function automatic logic [7:0] asra_crc8(input logic [15:0] d);
    logic [7:0] c;
    logic       fb;
    c = `ASRA_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ `ASRA_CRC_POLY;
      end
    end
    return c;
  endfunction

  // two-stage synchronisers plus one history stage for edge finding
  logic [2:0] sclk_sync_reg;
  logic [2:0] sel_sync_reg;
  logic [1:0] sdi_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_sync_reg <= 3'h0;
      sel_sync_reg  <= 3'h7;
      sdi_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], serial_clk};
      sel_sync_reg  <= {sel_sync_reg[1:0], frame_sel_n};
      sdi_sync_reg  <= {sdi_sync_reg[0], serial_command_in};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign sel_fall  = ~sel_sync_reg[1] & sel_sync_reg[2];
  assign sel_rise  = sel_sync_reg[1] & ~sel_sync_reg[2];

  asra_frame_t state_reg,     state_next;
  logic [4:0]  bit_cnt_reg,   bit_cnt_next;
  logic [23:0] in_sh_reg,     in_sh_next;
  logic [15:0] out_sh_reg,    out_sh_next;
  logic        sout_reg,      sout_next;
  logic        pend_reg,      pend_next;
  logic [2:0]  pend_idx_reg,  pend_idx_next;
  asra_data_t  cfg1_reg,      cfg1_next;
  asra_data_t  cfg2_reg,      cfg2_next;
  asra_data_t  low_reg,       low_next;
  asra_data_t  high_reg,      high_next;
  logic [5:0]  alarm_reg,     alarm_next;

  // read-back word for a register index
  function automatic logic [15:0] asra_readback(input logic [2:0] idx,
                                                input asra_data_t c1,
                                                input asra_data_t c2,
                                                input logic [5:0] al,
                                                input asra_data_t lo,
                                                input asra_data_t hi);
    asra_data_t d;
    d = 12'h000;
    unique case (idx)
      `ASRA_IDX_CFG1:     d = c1;
      `ASRA_IDX_CFG2:     d = c2;
      `ASRA_IDX_ALARM:    d = {2'h0, al[5:4], 2'h0, al[3:2], 2'h0, al[1:0]};
      `ASRA_IDX_LOW_LIM:  d = lo;
      `ASRA_IDX_HIGH_LIM: d = hi;
      default:            d = 12'h000;
    endcase
    return {1'b0, idx, d};
  endfunction

  logic [15:0] cmd;
  logic [7:0]  crc_rx;
  logic        is_wr;
  logic [2:0]  idx;
  logic        need_crc;
  logic        len_ok;
  logic [15:0] load_word;

  // frame sequencing, decode and register updates
  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    in_sh_next    = in_sh_reg;
    out_sh_next   = out_sh_reg;
    sout_next     = sout_reg;
    pend_next     = pend_reg;
    pend_idx_next = pend_idx_reg;
    cfg1_next     = cfg1_reg;
    cfg2_next     = cfg2_reg;
    low_next      = low_reg;
    high_next     = high_reg;
    // hardware events set sticky alarm bits; set beats clear below
    alarm_next    = alarm_reg;
    cmd           = (bit_cnt_reg == `ASRA_CRC_FRAME_BITS) ? in_sh_reg[23:8] : in_sh_reg[15:0];
    crc_rx        = in_sh_reg[7:0];
    is_wr         = cmd[`ASRA_DIR_BIT];
    idx           = cmd[`ASRA_IDX_HI:`ASRA_IDX_LO];
    need_crc      = cfg1_reg[`ASRA_CFG1_CRC_W_BIT] |
                    ((idx == `ASRA_IDX_CFG1) & cmd[`ASRA_CFG1_CRC_W_BIT]);
    len_ok        = (bit_cnt_reg == `ASRA_FRAME_BITS) |
                    (bit_cnt_reg == `ASRA_CRC_FRAME_BITS);
    load_word     = pend_reg ? asra_readback(pend_idx_reg, cfg1_reg, cfg2_reg, alarm_reg,
                                             low_reg, high_reg)
                             : conv_result_a;
    unique case (state_reg)
      ASRA_IDLE: begin
        sout_next = 1'b0;
        if (sel_fall) begin
          state_next   = ASRA_ACTIVE;
          bit_cnt_next = 5'd0;
          out_sh_next  = load_word;
          sout_next    = load_word[15];
          pend_next    = 1'b0;
          if (pend_reg && pend_idx_reg == `ASRA_IDX_ALARM) begin
            alarm_next = 6'h00;
          end
        end
      end
      ASRA_ACTIVE: begin
        if (sclk_rise) begin
          in_sh_next = {in_sh_reg[22:0], sdi_sync_reg[1]};
          // saturate well above 24 so over-long frames never look legal
          if (bit_cnt_reg != `ASRA_BIT_CNT_MAX) begin
            bit_cnt_next = bit_cnt_reg + 5'd1;
          end
        end
        if (sclk_fall) begin
          out_sh_next = {out_sh_reg[14:0], 1'b0};
          sout_next   = out_sh_reg[14];
        end
        if (sel_rise) begin
          state_next = ASRA_IDLE;
          sout_next  = 1'b0;
          // frames of wrong length are dropped, no read left pending
          if (len_ok) begin
            if (is_wr) begin
              if (need_crc && (bit_cnt_reg != `ASRA_CRC_FRAME_BITS ||
                               asra_crc8(cmd) != crc_rx)) begin
                alarm_next[5] = 1'b1;
              end else begin
                unique case (idx)
                  `ASRA_IDX_CFG1:     cfg1_next = cmd[11:0] & `ASRA_CFG1_WMASK;
                  `ASRA_IDX_CFG2:     cfg2_next = cmd[11:0] & `ASRA_CFG2_WMASK;
                  `ASRA_IDX_LOW_LIM:  low_next  = cmd[11:0];
                  `ASRA_IDX_HIGH_LIM: high_next = cmd[11:0];
                  default:            cfg1_next = cfg1_reg;
                endcase
              end
            end else begin
              // every defined register is readable, so no read is refused
              pend_next     = (idx >= `ASRA_IDX_CFG1) && (idx <= `ASRA_IDX_HIGH_LIM);
              pend_idx_next = idx;
            end
          end
        end
      end
    endcase
    if (setup_event)        alarm_next[4] = 1'b1;
    if (chan_b_over_event)  alarm_next[3] = 1'b1;
    if (chan_b_under_event) alarm_next[2] = 1'b1;
    if (chan_a_over_event)  alarm_next[1] = 1'b1;
    if (chan_a_under_event) alarm_next[0] = 1'b1;
  end

  // state registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg    <= ASRA_IDLE;
      bit_cnt_reg  <= 5'd0;
      in_sh_reg    <= 24'h000000;
      out_sh_reg   <= 16'h0000;
      sout_reg     <= 1'b0;
      pend_reg     <= 1'b0;
      pend_idx_reg <= 3'h0;
      cfg1_reg     <= `ASRA_CFG1_RESET;
      cfg2_reg     <= `ASRA_CFG2_RESET;
      low_reg      <= `ASRA_LOW_LIM_RESET;
      high_reg     <= `ASRA_HIGH_LIM_RESET;
      alarm_reg    <= 6'h00;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      in_sh_reg    <= in_sh_next;
      out_sh_reg   <= out_sh_next;
      sout_reg     <= sout_next;
      pend_reg     <= pend_next;
      pend_idx_reg <= pend_idx_next;
      cfg1_reg     <= cfg1_next;
      cfg2_reg     <= cfg2_next;
      low_reg      <= low_next;
      high_reg     <= high_next;
      alarm_reg    <= alarm_next;
    end
  end

  assign serial_out_a      = sout_reg;
  assign config_primary    = cfg1_reg;
  assign config_secondary  = cfg2_reg;
  assign lower_alarm_limit = low_reg;
  assign upper_alarm_limit = high_reg;
  assign alarm_flags       = alarm_reg;

endmodule
`default_nettype wire

/* File: asra_serial_regs_properties.sv */
// assertions on the serial register access block ports
`default_nettype none
module asra_serial_regs_properties
  import asra_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       frame_sel_n,
  input wire logic       serial_out_a,
  input wire logic       setup_event,
  input wire logic       chan_a_over_event,
  input wire logic       chan_a_under_event,
  input wire logic       chan_b_over_event,
  input wire logic       chan_b_under_event,
  input wire asra_data_t config_primary,
  input wire asra_data_t config_secondary,
  input wire asra_data_t lower_alarm_limit,
  input wire asra_data_t upper_alarm_limit,
  input wire logic [5:0] alarm_flags
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // register values at reset release
  property p_rst_vals;
    $rose(rst_n) |-> config_primary == 12'h000 && config_secondary == 12'h000 &&
      lower_alarm_limit == 12'h800 && upper_alarm_limit == 12'h7FF && alarm_flags == 6'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values");
  // reserved bits stay clear
  property p_cfg1_rsvd; config_primary[11:10] == 2'h0; endproperty
  a_cfg1_rsvd: assert property (p_cfg1_rsvd) else $error("cfg1 reserved set");
  property p_cfg2_rsvd; config_secondary[11:9] == 3'h0; endproperty
  a_cfg2_rsvd: assert property (p_cfg2_rsvd) else $error("cfg2 reserved set");
  // events set sticky flags
  property p_setup_set; setup_event |=> alarm_flags[4]; endproperty
  a_setup_set: assert property (p_setup_set) else $error("setup flag missed");
  property p_a_over_set; chan_a_over_event |=> alarm_flags[1]; endproperty
  a_a_over_set: assert property (p_a_over_set) else $error("a over flag missed");
  property p_a_under_set; chan_a_under_event |=> alarm_flags[0]; endproperty
  a_a_under_set: assert property (p_a_under_set) else $error("a under flag missed");
  property p_b_over_set; chan_b_over_event |=> alarm_flags[3]; endproperty
  a_b_over_set: assert property (p_b_over_set) else $error("b over flag missed");
  property p_b_under_set; chan_b_under_event |=> alarm_flags[2]; endproperty
  a_b_under_set: assert property (p_b_under_set) else $error("b under flag missed");
  // flags only clear inside a frame
  property p_clr_in_frame; alarm_flags != 6'h00 ##1 alarm_flags == 6'h00 |-> !frame_sel_n;
  endproperty
  a_clr_in_frame: assert property (p_clr_in_frame) else $error("flags cleared idle");
  // lane low between frames
  property p_idle_low; frame_sel_n [*8] |-> !serial_out_a; endproperty
  a_idle_low: assert property (p_idle_low) else $error("lane busy idle");
  // config and limit registers change only after frame end
  property p_chg_after_end;
    $changed({config_primary, config_secondary, lower_alarm_limit, upper_alarm_limit})
      |-> frame_sel_n && $past(frame_sel_n);
  endproperty
  a_chg_after_end: assert property (p_chg_after_end) else $error("write mid frame");
  c_frame: cover property ($fell(frame_sel_n));
  c_cfg_write: cover property ($changed(config_primary));
  c_bad_crc: cover property ($rose(alarm_flags[5]));
endmodule
`default_nettype wire

/* File: asra_host_model.sv */
// host model driving serial frames and capturing lane a
`default_nettype none
module asra_host_model (
  output logic      serial_clk,
  output logic      frame_sel_n,
  output logic      serial_command_in,
  input  wire logic serial_out_a
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: link clock parked low, select high
  initial begin
    serial_clk = 1'b0;
    frame_sel_n = 1'b1;
    serial_command_in = 1'b0;
  end
  // n-bit frame msb first, last 16 lane bits returned
  task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] rd);
    frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_command_in = w[i];
      #62.5 serial_clk = 1'b1;
      rd = {rd[14:0], serial_out_a};
      #62.5 serial_clk = 1'b0;
    end
    #62.5 frame_sel_n = 1'b1;
    serial_command_in = ~serial_command_in; // released line toggles
    #200;
  endtask
endmodule
`default_nettype wire

/* File: test_asra_serial_regs.sv */
// self-checking bench for the serial register access block
`default_nettype none
module test_asra_serial_regs
  import asra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] cmd; int n; logic [15:0] exp; bit chk;} asra_row_t;
  logic        clk_sys, rst_n;
  logic [4:0]  ev;
  logic [15:0] conv_result_a, rd;
  wire         serial_clk, frame_sel_n, serial_command_in, serial_out_a;
  wire [5:0]   alarm_flags;
  asra_data_t  config_primary, config_secondary, lower_alarm_limit, upper_alarm_limit;
  int          error_cnt = 0, num_checks = 0;
  // frame sequence: command, bits, expected returned word, compare
  asra_row_t rows[22] = '{
    '{16'h1000, 16, 16'hA5C3, 1}, '{16'h4000, 16, 16'h1000, 1}, '{16'h5000, 16, 16'h4800, 1},
    '{16'h2000, 16, 16'h57FF, 1}, '{16'hC123, 16, 16'h2000, 1}, '{16'hBFFF, 16, 16'hA5C3, 1},
    '{16'hF0AA, 16, 16'hA5C3, 1}, '{16'hD0FF, 12, 16'h0000, 0}, '{16'h4000, 16, 16'hA5C3, 1},
    '{16'h5000, 16, 16'h4123, 1}, '{16'hA3FF, 16, 16'h57FF, 1}, '{16'h9020, 16, 16'hA5C3, 1},
    '{16'h2000, 16, 16'hA5C3, 1}, '{16'h0000, 16, 16'h21FF, 1}, '{16'h3000, 16, 16'hA5C3, 1},
    '{16'h1000, 16, 16'h3200, 1}, '{16'h9020, 24, 16'h0000, 0}, '{16'hC055, 16, 16'hA5C3, 1},
    '{16'h1000, 16, 16'hA5C3, 1}, '{16'h3000, 16, 16'h1020, 1}, '{16'h4000, 16, 16'h3200, 1},
    '{16'h0000, 16, 16'h4123, 1}};
  asra_serial_regs asra_serial_regs_inst (.clk_sys, .rst_n, .serial_clk, .frame_sel_n,
    .serial_command_in, .conv_result_a, .setup_event(ev[4]), .chan_a_over_event(ev[1]),
    .chan_a_under_event(ev[0]), .chan_b_over_event(ev[3]), .chan_b_under_event(ev[2]),
    .serial_out_a,
    .config_primary, .config_secondary, .lower_alarm_limit, .upper_alarm_limit, .alarm_flags);
  asra_host_model asra_host_model_inst (.serial_clk, .frame_sel_n, .serial_command_in,
    .serial_out_a);
  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // checksum over the command word, msb first
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = (c << 1) ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // word compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // send one frame, 24-bit frames carry a checksum
  task automatic frame(input logic [15:0] c, input int n);
    logic [23:0] w;
    w = (n == 24) ? {c, crc8(c)} : 24'(c) >> (16 - n);
    asra_host_model_inst.xfer(w, n, rd);
  endtask
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  initial begin
    #300us;
    error_cnt++;
    test_done();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    ev = 5'h00;
    conv_result_a = 16'hA5C3;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      frame(rows[i].cmd, rows[i].n);
      if (rows[i].chk) chk(rd, rows[i].exp);
    end
    chk(16'(config_primary), 16'h0020);
    chk(16'(config_secondary), 16'h01FF);
    chk(16'(upper_alarm_limit), 16'h07FF);
    chk(16'(alarm_flags), 16'h0000);
    $display("table done");
    // distinct event groups so a swapped flag shows up in the word
    @(negedge clk_sys) ev = 5'h15;
    @(negedge clk_sys) ev = 5'h00;
    frame(16'h3000, 16);
    frame(16'h3000, 16);
    chk(rd, 16'h3111);
    @(negedge clk_sys) ev = 5'h0A;
    @(negedge clk_sys) ev = 5'h00;
    frame(16'h0000, 16);
    chk(rd, 16'h3022);
    $display("events done");
    // checksum still required: bad one dropped, good one lands
    @(negedge clk_sys) conv_result_a = 16'h3CA5;
    asra_host_model_inst.xfer({16'hC0AB, ~crc8(16'hC0AB)}, 24, rd);
    chk(16'(alarm_flags), 16'h0020);
    frame(16'hC055, 24);
    frame(16'h4000, 16);
    chk(rd, 16'h3CA5);
    frame(16'h3000, 16);
    chk(rd, 16'h4055);
    frame(16'h0000, 16);
    chk(rd, 16'h3200);
    $display("checksum done");
    @(negedge clk_sys) rst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    chk(16'(lower_alarm_limit), 16'h0800);
    repeat (4) @(negedge clk_sys);
    frame(16'h1000, 16);
    frame(16'h0000, 16);
    chk(rd, 16'h1000);
    $display("reset done");
    test_done();
  end
endmodule
bind asra_serial_regs asra_serial_regs_properties asra_serial_regs_properties_inst (
  .clk_sys, .rst_n, .frame_sel_n, .serial_out_a, .setup_event, .chan_a_over_event,
  .chan_a_under_event, .chan_b_over_event, .chan_b_under_event,
  .config_primary, .config_secondary, .lower_alarm_limit, .upper_alarm_limit, .alarm_flags);
`default_nettype wire
